// ==== src/dpbwc_params.svh ====
// Offsets, field positions, reset values and hardwired codes of the downstream port bridge
`ifndef DPBWC_PARAMS_SVH
`define DPBWC_PARAMS_SVH
`define DPBWC_OFF_IO_BASE 8'h1C
`define DPBWC_OFF_IO_LIMIT 8'h1D
`define DPBWC_OFF_MEM_BASE 8'h20
`define DPBWC_OFF_MEM_LIMIT 8'h22
`define DPBWC_OFF_PREF_BASE 8'h24
`define DPBWC_OFF_PREF_LIMIT 8'h26
`define DPBWC_OFF_PREF_BASE_HIGH 8'h28
`define DPBWC_OFF_PREF_TOP_HIGH 8'h2C
`define DPBWC_OFF_IO_BOTTOM_HIGH 8'h30
`define DPBWC_OFF_IO_TOP_HIGH 8'h32
`define DPBWC_OFF_CAP_LIST 8'h34
`define DPBWC_OFF_INT_LINE 8'h3C
`define DPBWC_OFF_INT_PIN 8'h3D
`define DPBWC_OFF_BRIDGE_CTRL 8'h3E
`define DPBWC_CAP_LIST_VALUE 8'h50
`define DPBWC_INT_LINE_RESET 8'hFF
`define DPBWC_INT_PIN_VALUE 8'h01
`define DPBWC_IO_TYPE_VALUE 4'h1
`define DPBWC_PREF_TYPE_VALUE 4'h1
`define DPBWC_BRIDGE_CTRL_RESET 16'h0000
`define DPBWC_BRIDGE_CTRL_WMASK 16'h005F
`define DPBWC_BC_POISON_RESP 0
`define DPBWC_BC_ERR_FWD 1
`define DPBWC_BC_LEGACY_IO 2
`define DPBWC_BC_LEGACY_DISP 3
`define DPBWC_BC_DISP_FULL 4
`define DPBWC_BC_SEC_RESET 6
`define DPBWC_DISP_MEM_LOW 64'h00000000000A0000
`define DPBWC_DISP_MEM_HIGH 64'h00000000000BFFFF
`define DPBWC_DISP_IO_A_LOW 10'h3B0
`define DPBWC_DISP_IO_A_HIGH 10'h3BB
`define DPBWC_DISP_IO_B_LOW 10'h3C0
`define DPBWC_DISP_IO_B_HIGH 10'h3DF
`define DPBWC_IO_LOW_ONES 12'hFFF
`define DPBWC_MEM_LOW_ONES 20'hFFFFF
`endif

// ==== src/dpbwc_pkg.sv ====
// Types shared by the downstream port bridge files
package dpbwc_pkg;
  typedef enum logic [2:0]
  {
    LINK_ACTIVE = 3'b001,
    LINK_HOT_RESET = 3'b010,
    LINK_RETRAIN = 3'b100
  } link_state_type;
endpackage : dpbwc_pkg

// ==== src/dpbwc_fwd_decode.sv ====
// Forwarding decision for one transaction against the windows and legacy decode bits
`timescale 1ns/10ps
`include "dpbwc_params.svh"
module dpbwc_fwd_decode
(
  // Transaction
  input wire logic txnUpstream,
  input wire logic txnIsIo,
  input wire logic [63:0] txnAddr,
  // Assembled windows
  input wire logic [31:0] ioBase,
  input wire logic [31:0] io_top_field,
  input wire logic [31:0] memBase,
  input wire logic [31:0] memLimit,
  input wire logic [63:0] prefBase,
  input wire logic [63:0] prefLimit,
  // Control
  input wire logic legacyDisplay,
  input wire logic legacyDisplayFull,
  input wire logic legacyIoBlock,
  input wire logic cmdMemEnable,
  input wire logic cmdIoEnable,
  // Decision
  output logic forwardHit
);
  function automatic logic inRange(input logic [63:0] a, input logic [63:0] lo, input logic [63:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  logic inIo;
  logic inMem;
  logic dispMem;
  logic dispIo;
  logic legacyIoAlias;
  logic first64k;

  always_comb
  begin
    first64k = (txnAddr[63:16] == 48'h000000000000);
    inIo = inRange(txnAddr, {32'h00000000, ioBase}, {32'h00000000, io_top_field}); // R21
    inMem = inRange(txnAddr, {32'h00000000, memBase}, {32'h00000000, memLimit})
      || inRange(txnAddr, prefBase, prefLimit); // R21
    dispMem = inRange(txnAddr, `DPBWC_DISP_MEM_LOW, `DPBWC_DISP_MEM_HIGH); // R10
    // Aliases above bit 9 pass unless full decode asks for them to be zero
    dispIo = first64k
      && (!legacyDisplayFull || txnAddr[15:10] == 6'h00) // R12
      && (inRange({54'h0, txnAddr[9:0]}, {54'h0, `DPBWC_DISP_IO_A_LOW}, {54'h0, `DPBWC_DISP_IO_A_HIGH})
      || inRange({54'h0, txnAddr[9:0]}, {54'h0, `DPBWC_DISP_IO_B_LOW}, {54'h0, `DPBWC_DISP_IO_B_HIGH})); // R11
    // Top 768 bytes of each kilobyte: bits 9:8 not both zero
    legacyIoAlias = legacyIoBlock && inIo && first64k && (txnAddr[9:8] != 2'b00); // R15 R16
    forwardHit = 1'b0;
    if (!txnUpstream)
    begin
      if (txnIsIo)
      begin
        if (legacyDisplay && dispIo)
          forwardHit = cmdIoEnable; // R13 R14
        else
          forwardHit = cmdIoEnable && inIo && !legacyIoAlias; // R15
      end
      else
      begin
        if (legacyDisplay && dispMem)
          forwardHit = cmdMemEnable; // R13 R14
        else
          forwardHit = cmdMemEnable && inMem; // R21
      end
    end
    else
    begin
      if (txnIsIo)
        forwardHit = !(legacyDisplay && dispIo) && (legacyIoAlias || !inIo); // R13 R16
      else
        forwardHit = !(legacyDisplay && dispMem) && !inMem; // R13
    end
  end
endmodule : dpbwc_fwd_decode

// ==== src/dpbwc_port_bridge.sv ====
// Downstream port bridge: type-1 window registers, bridge control and forwarding decisions
//
// Notes on behaviour
// R1: 32-bit writable high half of the prefetchable window top address.
// R2: 16-bit writable high bits of the I/O window bottom, reset zero.
// R3: 16-bit writable high bits of the I/O window top, reset zero.
// R4: Capability pointer always reads 50h; writes are ignored.
// R5: Interrupt line is scratch, resets to FFh, steers nothing.
// R6: Interrupt pin reads 01h, first legacy pin, read only.
// R7: Downstream legacy interrupts go upstream as from this bridge's primary side.
// R8: Bridge control bits 15:5 except 6 read zero and ignore writes.
// R9: Secondary reset bit drives a hot reset sequence and reads back set.
// R10: Legacy display decode forwards A0000h to BFFFFh memory downstream.
// R11: Legacy display decode forwards 3B0h-3BBh and 3C0h-3DFh I/O in first 64K.
// R12: Full decode bit requires I/O bits 15:10 zero for display decode.
// R13: Display addresses blocked upstream; decode ignores legacy I/O bit and windows.
// R14: Display forwarding still needs memory enable or I/O enable.
// R15: Legacy I/O block stops downstream I/O in top 768 bytes per kilobyte of the first 64K.
// R16: Legacy I/O block forwards those upstream I/O accesses instead.
// R17: Errors go upstream only with error forward, command enable and error.
// R18: Poison response bit enables responses to poisoned downstream packets.
// R19: Low I/O limit gives bits 15:12, low twelve bits all ones.
// R20: Low prefetch fields give bits 31:20 joined with the high halves.
// R21: Forward downstream when address lies inside an assembled window.
`timescale 1ns/10ps
`include "dpbwc_params.svh"
module dpbwc_port_bridge
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Configuration access
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  output logic [31:0] cfgReadData,
  output logic cfgReadValid,
  // Command register bits
  input wire logic cmdMemEnable,
  input wire logic cmdIoEnable,
  input wire logic cmdSerrEnable,
  // Transaction decode
  input wire logic txnValid,
  input wire logic txnUpstream,
  input wire logic txnIsIo,
  input wire logic [63:0] txnAddr,
  output logic txnDoneValid,
  output logic txnForward,
  // Secondary link events
  input wire logic secFatalError,
  input wire logic secNonfatalError,
  input wire logic poisonedTlpSeen,
  input wire logic downIntxAssert,
  output logic errorReportUp,
  output logic poisonResponse,
  output logic upIntxAssert,
  // Link reset sequencing
  output logic linkHotReset,
  output logic linkRetrain
);
  logic [7:0] ioBaseLow_r;
  logic [7:0] ioLimitLow_r;
  logic [15:0] memBaseLow_r;
  logic [15:0] memLimitLow_r;
  logic [15:0] prefBaseLow_r;
  logic [15:0] prefLimitLow_r;
  logic [31:0] prefBaseHigh_r;
  logic [31:0] prefTopHigh_r;
  logic [15:0] ioBottomHigh_r;
  logic [15:0] ioTopHigh_r;
  logic [7:0] intLine_r;
  logic [15:0] bridgeCtrl_r;
  logic [31:0] cfgReadData_r;
  logic cfgReadValid_r;
  logic txnDoneValid_r;
  logic txnForward_r;
  logic errorReportUp_r;
  logic poisonResponse_r;
  logic upIntxAssert_r;
  logic linkHotReset_r;
  logic linkRetrain_r;
  dpbwc_pkg::link_state_type linkState_r;
  dpbwc_pkg::link_state_type linkState_nxt;
  logic [31:0] cfgReadData_nxt;
  logic forwardHit;

  // Byte-lane merge of a write into one config dword
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    mergeLanes = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        mergeLanes[i*8 +: 8] = wd[i*8 +: 8];
  endfunction : mergeLanes

  function automatic logic dwordHit(input logic [7:0] a, input logic [7:0] off);
    dwordHit = (a[7:2] == off[7:2]);
  endfunction : dwordHit

  // Dword images, hardwired fields filled in
  logic [31:0] ioDword;
  logic [31:0] memDword;
  logic [31:0] prefDword;
  logic [31:0] ioHighDword;
  logic [31:0] intDword;
  logic [31:0] ioWr;
  logic [31:0] memWr;
  logic [31:0] prefWr;
  logic [31:0] ioHighWr;
  logic [31:0] intWr;

  always_comb
  begin
    // Secondary status at 1Eh is kept outside this block and reads zero here
    ioDword = {16'h0000, ioLimitLow_r[7:4], `DPBWC_IO_TYPE_VALUE, ioBaseLow_r[7:4], `DPBWC_IO_TYPE_VALUE};
    memDword = {memLimitLow_r[15:4], 4'h0, memBaseLow_r[15:4], 4'h0};
    prefDword = {prefLimitLow_r[15:4], `DPBWC_PREF_TYPE_VALUE, prefBaseLow_r[15:4], `DPBWC_PREF_TYPE_VALUE};
    ioHighDword = {ioTopHigh_r, ioBottomHigh_r};
    intDword = {bridgeCtrl_r, `DPBWC_INT_PIN_VALUE, intLine_r}; // R6
    ioWr = mergeLanes(ioDword, cfgWriteData, cfgByteEn);
    memWr = mergeLanes(memDword, cfgWriteData, cfgByteEn);
    prefWr = mergeLanes(prefDword, cfgWriteData, cfgByteEn);
    ioHighWr = mergeLanes(ioHighDword, cfgWriteData, cfgByteEn);
    intWr = mergeLanes(intDword, cfgWriteData, cfgByteEn);
  end

  // I/O window low bytes
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ioBaseLow_r <= 8'h01;
      ioLimitLow_r <= 8'h01;
    end
    else if (cfgWrite && dwordHit(cfgAddr, `DPBWC_OFF_IO_BASE))
    begin
      ioBaseLow_r <= {ioWr[7:4], `DPBWC_IO_TYPE_VALUE};
      ioLimitLow_r <= {ioWr[15:12], `DPBWC_IO_TYPE_VALUE}; // R19
    end
  end

  // Memory window low halves
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      memBaseLow_r <= 16'h0000;
      memLimitLow_r <= 16'h0000;
    end
    else if (cfgWrite && dwordHit(cfgAddr, `DPBWC_OFF_MEM_BASE))
    begin
      memBaseLow_r <= {memWr[15:4], 4'h0};
      memLimitLow_r <= {memWr[31:20], 4'h0};
    end
  end

  // Prefetchable window low halves
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prefBaseLow_r <= 16'h0001;
      prefLimitLow_r <= 16'h0001;
    end
    else if (cfgWrite && dwordHit(cfgAddr, `DPBWC_OFF_PREF_BASE))
    begin
      prefBaseLow_r <= {prefWr[15:4], `DPBWC_PREF_TYPE_VALUE}; // R20
      prefLimitLow_r <= {prefWr[31:20], `DPBWC_PREF_TYPE_VALUE}; // R20
    end
  end

  // Prefetchable window high halves
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prefBaseHigh_r <= 32'h00000000;
      prefTopHigh_r <= 32'h00000000;
    end
    else if (cfgWrite)
    begin
      if (dwordHit(cfgAddr, `DPBWC_OFF_PREF_BASE_HIGH))
        prefBaseHigh_r <= mergeLanes(prefBaseHigh_r, cfgWriteData, cfgByteEn);
      if (dwordHit(cfgAddr, `DPBWC_OFF_PREF_TOP_HIGH))
        prefTopHigh_r <= mergeLanes(prefTopHigh_r, cfgWriteData, cfgByteEn); // R1
    end
  end

  // I/O window high halves
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ioBottomHigh_r <= 16'h0000;
      ioTopHigh_r <= 16'h0000;
    end
    else if (cfgWrite && dwordHit(cfgAddr, `DPBWC_OFF_IO_BOTTOM_HIGH))
    begin
      ioBottomHigh_r <= ioHighWr[15:0]; // R2
      ioTopHigh_r <= ioHighWr[31:16]; // R3
    end
  end

  // Interrupt line scratch and bridge control; pin byte has no storage
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      intLine_r <= `DPBWC_INT_LINE_RESET; // R5
      bridgeCtrl_r <= `DPBWC_BRIDGE_CTRL_RESET;
    end
    else if (cfgWrite && dwordHit(cfgAddr, `DPBWC_OFF_INT_LINE))
    begin
      intLine_r <= intWr[7:0]; // R5
      bridgeCtrl_r <= intWr[31:16] & `DPBWC_BRIDGE_CTRL_WMASK; // R8
    end
  end

  // Read mux; unmapped dwords read zero
  always_comb
  begin
    cfgReadData_nxt = 32'h00000000;
    if (dwordHit(cfgAddr, `DPBWC_OFF_IO_BASE))
      cfgReadData_nxt = ioDword;
    else if (dwordHit(cfgAddr, `DPBWC_OFF_MEM_BASE))
      cfgReadData_nxt = memDword;
    else if (dwordHit(cfgAddr, `DPBWC_OFF_PREF_BASE))
      cfgReadData_nxt = prefDword;
    else if (dwordHit(cfgAddr, `DPBWC_OFF_PREF_BASE_HIGH))
      cfgReadData_nxt = prefBaseHigh_r;
    else if (dwordHit(cfgAddr, `DPBWC_OFF_PREF_TOP_HIGH))
      cfgReadData_nxt = prefTopHigh_r; // R1
    else if (dwordHit(cfgAddr, `DPBWC_OFF_IO_BOTTOM_HIGH))
      cfgReadData_nxt = ioHighDword; // R2 R3
    else if (dwordHit(cfgAddr, `DPBWC_OFF_CAP_LIST))
      cfgReadData_nxt = {24'h000000, `DPBWC_CAP_LIST_VALUE}; // R4
    else if (dwordHit(cfgAddr, `DPBWC_OFF_INT_LINE))
      cfgReadData_nxt = intDword; // R6 R8
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgReadData_r <= 32'h00000000;
      cfgReadValid_r <= 1'b0;
    end
    else
    begin
      cfgReadValid_r <= cfgRead;
      if (cfgRead)
        cfgReadData_r <= cfgReadData_nxt;
    end
  end

  dpbwc_fwd_decode u_decode
  (
    .txnUpstream(txnUpstream),
    .txnIsIo(txnIsIo),
    .txnAddr(txnAddr),
    .ioBase({ioBottomHigh_r, ioBaseLow_r[7:4], 12'h000}),
    .io_top_field({ioTopHigh_r, ioLimitLow_r[7:4], `DPBWC_IO_LOW_ONES}),
    .memBase({memBaseLow_r[15:4], 20'h00000}),
    .memLimit({memLimitLow_r[15:4], `DPBWC_MEM_LOW_ONES}),
    .prefBase({prefBaseHigh_r, prefBaseLow_r[15:4], 20'h00000}),
    .prefLimit({prefTopHigh_r, prefLimitLow_r[15:4], `DPBWC_MEM_LOW_ONES}),
    .legacyDisplay(bridgeCtrl_r[`DPBWC_BC_LEGACY_DISP]),
    .legacyDisplayFull(bridgeCtrl_r[`DPBWC_BC_DISP_FULL]),
    .legacyIoBlock(bridgeCtrl_r[`DPBWC_BC_LEGACY_IO]),
    .cmdMemEnable(cmdMemEnable),
    .cmdIoEnable(cmdIoEnable),
    .forwardHit(forwardHit)
  );

  // Decision one cycle after the request
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      txnDoneValid_r <= 1'b0;
      txnForward_r <= 1'b0;
    end
    else
    begin
      txnDoneValid_r <= txnValid;
      txnForward_r <= txnValid && forwardHit; // R21
    end
  end

  // Event forwarding; registered so each is a clean one-cycle pulse or level
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      errorReportUp_r <= 1'b0;
      poisonResponse_r <= 1'b0;
      upIntxAssert_r <= 1'b0;
    end
    else
    begin
      errorReportUp_r <= bridgeCtrl_r[`DPBWC_BC_ERR_FWD] && cmdSerrEnable
        && (secFatalError || secNonfatalError); // R17
      poisonResponse_r <= bridgeCtrl_r[`DPBWC_BC_POISON_RESP] && poisonedTlpSeen; // R18
      upIntxAssert_r <= downIntxAssert; // R7
    end
  end

  // Hot reset held while the bit is set, then one retrain cycle
  always_comb
  begin
    case (linkState_r)
      dpbwc_pkg::LINK_ACTIVE:
        linkState_nxt = bridgeCtrl_r[`DPBWC_BC_SEC_RESET] ? dpbwc_pkg::LINK_HOT_RESET : dpbwc_pkg::LINK_ACTIVE;
      dpbwc_pkg::LINK_HOT_RESET:
        linkState_nxt = bridgeCtrl_r[`DPBWC_BC_SEC_RESET] ? dpbwc_pkg::LINK_HOT_RESET : dpbwc_pkg::LINK_RETRAIN;
      dpbwc_pkg::LINK_RETRAIN:
        linkState_nxt = bridgeCtrl_r[`DPBWC_BC_SEC_RESET] ? dpbwc_pkg::LINK_HOT_RESET : dpbwc_pkg::LINK_ACTIVE;
      default:
        linkState_nxt = dpbwc_pkg::LINK_ACTIVE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      linkState_r <= dpbwc_pkg::LINK_ACTIVE;
      linkHotReset_r <= 1'b0;
      linkRetrain_r <= 1'b0;
    end
    else
    begin
      linkState_r <= linkState_nxt; // R9
      linkHotReset_r <= (linkState_nxt == dpbwc_pkg::LINK_HOT_RESET); // R9
      linkRetrain_r <= (linkState_nxt == dpbwc_pkg::LINK_RETRAIN);
    end
  end

  assign cfgReadData = cfgReadData_r;
  assign cfgReadValid = cfgReadValid_r;
  assign txnDoneValid = txnDoneValid_r;
  assign txnForward = txnForward_r;
  assign errorReportUp = errorReportUp_r;
  assign poisonResponse = poisonResponse_r;
  assign upIntxAssert = upIntxAssert_r;
  assign linkHotReset = linkHotReset_r;
  assign linkRetrain = linkRetrain_r;
endmodule : dpbwc_port_bridge

// ==== testbench/dpbwc_port_bridge_checker.sv ====
// Port-level checks of the downstream port bridge
`timescale 1ns/10ps
module dpbwc_port_bridge_checker
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Configuration access
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  input wire logic [31:0] cfgReadData,
  input wire logic cfgReadValid,
  // Command bits
  input wire logic cmdMemEnable,
  input wire logic cmdIoEnable,
  input wire logic cmdSerrEnable,
  // Transactions
  input wire logic txnValid,
  input wire logic txnUpstream,
  input wire logic txnIsIo,
  input wire logic [63:0] txnAddr,
  input wire logic txnDoneValid,
  input wire logic txnForward,
  // Link events
  input wire logic secFatalError,
  input wire logic secNonfatalError,
  input wire logic poisonedTlpSeen,
  input wire logic downIntxAssert,
  input wire logic errorReportUp,
  input wire logic poisonResponse,
  input wire logic upIntxAssert,
  input wire logic linkHotReset,
  input wire logic linkRetrain
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence readCapDword;
    cfgRead && cfgAddr[7:2] == 6'h0D;
  endsequence
  sequence readCtrlDword;
    cfgRead && cfgAddr[7:2] == 6'h0F;
  endsequence
  sequence hotResetEnds;
    linkHotReset ##1 !linkHotReset;
  endsequence
  chk_cap_ptr_fixed: assert property (readCapDword |=> cfgReadValid && cfgReadData[7:0] == 8'h50)
    else $error("capability pointer read wrong");
  chk_int_pin_fixed: assert property (readCtrlDword |=> cfgReadValid && cfgReadData[15:8] == 8'h01)
    else $error("interrupt pin read wrong");
  chk_ctrl_reserved_zero: assert property (readCtrlDword |=> cfgReadData[31:23] == 9'h000 && !cfgReadData[21])
    else $error("hardwired control bits not zero");
  chk_intx_passed_up: assert property (1'h1 |=> upIntxAssert == $past(downIntxAssert))
    else $error("legacy interrupt not passed up");
  chk_error_fwd_gate: assert property (errorReportUp |-> $past(cmdSerrEnable)
    && ($past(secFatalError) || $past(secNonfatalError)))
    else $error("error forwarded without cause");
  chk_poison_gate: assert property (poisonResponse |-> $past(poisonedTlpSeen))
    else $error("poison response without poisoned packet");
  chk_txn_answer_next: assert property (txnValid |=> txnDoneValid)
    else $error("no decision one cycle after request");
  chk_fwd_with_done: assert property (txnForward |-> txnDoneValid)
    else $error("forward outside decision cycle");
  chk_enable_gate: assert property (txnValid && !txnUpstream && (txnIsIo ? !cmdIoEnable : !cmdMemEnable)
    |=> !txnForward)
    else $error("downstream forward with enable clear");
  chk_retrain_after: assert property (hotResetEnds |-> linkRetrain ##1 !linkRetrain)
    else $error("no single retrain pulse after hot reset");
endmodule : dpbwc_port_bridge_checker

bind dpbwc_port_bridge dpbwc_port_bridge_checker checker_i
(
  .clock(clock), .resetn(resetn), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
  .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
  .cmdMemEnable(cmdMemEnable), .cmdIoEnable(cmdIoEnable), .cmdSerrEnable(cmdSerrEnable),
  .txnValid(txnValid), .txnUpstream(txnUpstream), .txnIsIo(txnIsIo), .txnAddr(txnAddr),
  .txnDoneValid(txnDoneValid), .txnForward(txnForward), .secFatalError(secFatalError),
  .secNonfatalError(secNonfatalError), .poisonedTlpSeen(poisonedTlpSeen), .downIntxAssert(downIntxAssert),
  .errorReportUp(errorReportUp), .poisonResponse(poisonResponse), .upIntxAssert(upIntxAssert),
  .linkHotReset(linkHotReset), .linkRetrain(linkRetrain)
);

// ==== testbench/dpbwc_down_device.sv ====
// Model of the device on the secondary link, raising its events on request
`timescale 1ns/10ps
module dpbwc_down_device
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link reset from the port
  input wire logic linkHotReset,
  input wire logic linkRetrain,
  // Requests from the bench
  input wire logic raiseFatal,
  input wire logic raiseNonfatal,
  input wire logic sendPoison,
  input wire logic intxReq,
  // Events toward the port
  output logic secFatalError,
  output logic secNonfatalError,
  output logic poisonedTlpSeen,
  output logic downIntxAssert
);
  logic inReset_r;
  // A device held in hot reset stays silent until the link retrains
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      inReset_r <= 1'h0;
    else if (linkHotReset)
      inReset_r <= 1'h1;
    else if (linkRetrain)
      inReset_r <= 1'h0;
  end
  assign secFatalError = raiseFatal & !inReset_r;
  assign secNonfatalError = raiseNonfatal & !inReset_r;
  assign poisonedTlpSeen = sendPoison & !inReset_r;
  assign downIntxAssert = intxReq & !inReset_r;
endmodule : dpbwc_down_device

// ==== testbench/tb.sv ====
// Self-checking bench for the downstream port bridge
`timescale 1ns/10ps
`define CHECK_EQ(nm, e, g) begin nTests++; if ((g) !== (e)) begin failCount++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic cfgWrite = 1'h0;
  logic cfgRead = 1'h0;
  logic [7:0] cfgAddr = 8'h00;
  logic [3:0] cfgByteEn = 4'h0;
  logic [31:0] cfgWriteData = 32'h00000000;
  logic cmdMemEnable = 1'h1;
  logic cmdIoEnable = 1'h1;
  logic cmdSerrEnable = 1'h0;
  logic txnValid = 1'h0;
  logic txnUpstream = 1'h0;
  logic txnIsIo = 1'h0;
  logic [63:0] txnAddr = 64'h0;
  logic raiseFatal = 1'h0;
  logic raiseNonfatal = 1'h0;
  logic sendPoison = 1'h0;
  logic intxReq = 1'h0;
  logic [31:0] cfgReadData;
  logic cfgReadValid, txnDoneValid, txnForward, secFatalError, secNonfatalError, poisonedTlpSeen;
  logic downIntxAssert, errorReportUp, poisonResponse, upIntxAssert, linkHotReset, linkRetrain;
  int failCount = 0;
  int nTests = 0;
  int cycles = 0;
  int i;

  dpbwc_port_bridge dut
  (
    .clock(clock), .resetn(resetn), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
    .cmdMemEnable(cmdMemEnable), .cmdIoEnable(cmdIoEnable), .cmdSerrEnable(cmdSerrEnable),
    .txnValid(txnValid), .txnUpstream(txnUpstream), .txnIsIo(txnIsIo), .txnAddr(txnAddr),
    .txnDoneValid(txnDoneValid), .txnForward(txnForward), .secFatalError(secFatalError),
    .secNonfatalError(secNonfatalError), .poisonedTlpSeen(poisonedTlpSeen), .downIntxAssert(downIntxAssert),
    .errorReportUp(errorReportUp), .poisonResponse(poisonResponse), .upIntxAssert(upIntxAssert),
    .linkHotReset(linkHotReset), .linkRetrain(linkRetrain)
  );

  dpbwc_down_device farDevice
  (
    .clock(clock), .resetn(resetn), .linkHotReset(linkHotReset), .linkRetrain(linkRetrain),
    .raiseFatal(raiseFatal), .raiseNonfatal(raiseNonfatal), .sendPoison(sendPoison), .intxReq(intxReq),
    .secFatalError(secFatalError), .secNonfatalError(secNonfatalError), .poisonedTlpSeen(poisonedTlpSeen),
    .downIntxAssert(downIntxAssert)
  );

  always #10 clock = ~clock;

  task automatic reportAndStop;
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : reportAndStop

  // Bounded so a hung bridge still reaches the verdict
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      failCount++;
      reportAndStop();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfgWrite <= 1'h1;
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWriteData <= d;
    @(posedge clock);
    cfgWrite <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    cfgRead <= 1'h1;
    cfgAddr <= a;
    @(posedge clock);
    cfgRead <= 1'h0;
    #1;
    `CHECK_EQ("read valid", 1'h1, cfgReadValid)
    `CHECK_EQ("read data", e, cfgReadData)
  endtask : rd

  task automatic ctl(input logic [15:0] v);
    wr(8'h3E, 4'hC, {v, 16'h0000});
  endtask : ctl

  task automatic txn(input logic up, input logic io, input logic [63:0] a, input logic e);
    @(posedge clock);
    txnValid <= 1'h1;
    txnUpstream <= up;
    txnIsIo <= io;
    txnAddr <= a;
    @(posedge clock);
    txnValid <= 1'h0;
    #1;
    `CHECK_EQ("decision", 1'h1, txnDoneValid)
    `CHECK_EQ("forward", e, txnForward)
  endtask : txn

  // Link outputs follow the control bit exactly one edge later
  task automatic waitLink(input logic hot, input logic retrain);
    @(posedge clock);
    #1;
    `CHECK_EQ("link state", {hot, retrain}, {linkHotReset, linkRetrain})
  endtask : waitLink

  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'h1;
    rd(8'h2C, 32'h00000000);
    rd(8'h30, 32'h00000000);
    rd(8'h34, 32'h00000050);
    rd(8'h3C, 32'h000001FF);
    $display("test reset_values done");
    wr(8'h2C, 4'hF, 32'hFFFFFFFF);
    rd(8'h2C, 32'hFFFFFFFF);
    wr(8'h30, 4'hF, 32'h12345678);
    rd(8'h30, 32'h12345678);
    wr(8'h34, 4'hF, 32'hFFFFFFFF);
    rd(8'h34, 32'h00000050);
    wr(8'h3C, 4'hF, 32'hFFBFFF55);
    rd(8'h3C, 32'h001F0155);
    wr(8'h44, 4'hF, 32'hFFFFFFFF);
    rd(8'h44, 32'h00000000);
    $display("test register_access done");
    ctl(16'h0040);
    waitLink(1'h1, 1'h0);
    rd(8'h3C, 32'h00400155);
    ctl(16'h0000);
    waitLink(1'h0, 1'h1);
    waitLink(1'h0, 1'h0);
    $display("test secondary_reset done");
    for (i = 0; i < 16; i++)
    begin
      ctl({14'h0000, i[3], i[3]});
      @(posedge clock);
      cmdSerrEnable <= i[2];
      raiseFatal <= i[1];
      raiseNonfatal <= i[0];
      sendPoison <= i[0];
      intxReq <= i[1];
      @(posedge clock);
      raiseFatal <= 1'h0;
      raiseNonfatal <= 1'h0;
      sendPoison <= 1'h0;
      #1;
      `CHECK_EQ("error up", i[3] & i[2] & (i[1] | i[0]), errorReportUp)
      `CHECK_EQ("poison response", i[3] & i[0], poisonResponse)
      `CHECK_EQ("interrupt up", i[1], upIntxAssert)
    end
    $display("test link_events done");
    wr(8'h30, 4'hF, 32'h00010001);
    wr(8'h1C, 4'h3, 32'h00002010);
    rd(8'h1C, 32'h00002111);
    wr(8'h20, 4'hF, 32'h0000FFF0);
    wr(8'h24, 4'hF, 32'h00100010);
    wr(8'h2C, 4'hF, 32'h00000001);
    ctl(16'h0000);
    txn(1'h0, 1'h1, 64'h11000, 1'h1);
    txn(1'h0, 1'h1, 64'h12FFF, 1'h1);
    txn(1'h0, 1'h1, 64'h01000, 1'h0);
    wr(8'h30, 4'hF, 32'h00000000);
    txn(1'h0, 1'h0, 64'h100000000, 1'h1);
    txn(1'h0, 1'h0, 64'h1001FFFFF, 1'h1);
    txn(1'h0, 1'h0, 64'h100200000, 1'h0);
    txn(1'h0, 1'h0, 64'hA0000, 1'h0);
    txn(1'h0, 1'h1, 64'h2FFF, 1'h1);
    txn(1'h0, 1'h1, 64'h3000, 1'h0);
    txn(1'h0, 1'h1, 64'h1100, 1'h1);
    ctl(16'h0004);
    txn(1'h0, 1'h1, 64'h1100, 1'h0);
    txn(1'h0, 1'h1, 64'h1000, 1'h1);
    txn(1'h1, 1'h1, 64'h1100, 1'h1);
    txn(1'h1, 1'h1, 64'h1000, 1'h0);
    ctl(16'h0008);
    txn(1'h0, 1'h0, 64'hA0000, 1'h1);
    txn(1'h0, 1'h0, 64'hBFFFF, 1'h1);
    txn(1'h0, 1'h0, 64'hC0000, 1'h0);
    txn(1'h0, 1'h1, 64'h3B0, 1'h1);
    txn(1'h0, 1'h1, 64'h3BB, 1'h1);
    txn(1'h0, 1'h1, 64'h3BC, 1'h0);
    txn(1'h0, 1'h1, 64'h3DF, 1'h1);
    txn(1'h0, 1'h1, 64'h3E0, 1'h0);
    txn(1'h0, 1'h1, 64'h103C0, 1'h0);
    txn(1'h0, 1'h1, 64'h43C0, 1'h1);
    txn(1'h1, 1'h0, 64'hA0000, 1'h0);
    txn(1'h1, 1'h0, 64'hC0000, 1'h1);
    txn(1'h1, 1'h1, 64'h3C0, 1'h0);
    ctl(16'h0018);
    txn(1'h0, 1'h1, 64'h43C0, 1'h0);
    txn(1'h0, 1'h1, 64'h3C0, 1'h1);
    ctl(16'h0010);
    txn(1'h0, 1'h1, 64'h3C0, 1'h0);
    ctl(16'h000C);
    txn(1'h0, 1'h1, 64'h13C0, 1'h1);
    @(posedge clock);
    cmdMemEnable <= 1'h0;
    cmdIoEnable <= 1'h0;
    txn(1'h0, 1'h0, 64'hA0000, 1'h0);
    txn(1'h0, 1'h1, 64'h3C0, 1'h0);
    $display("test forwarding done");
    reportAndStop();
  end
endmodule : tb
